// ==== adcf_top.sv ====
`timescale 1ns/10ps
`include "adcf_cfg.svh"
module adcf_top #(
   parameter int NCH = 8,
   parameter int CH_W = 3,
   parameter int HYS_W = 8
) (
   // System clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Serial link pins
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   input wire logic daisy_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic alarm_o,
   // Converter core
   output logic conv_start_o,
   output logic [CH_W-1:0] conv_ch_o,
   input wire logic conv_done_i,
   input wire logic [`ADCF_CODE_W-1:0] conv_code_i,
   // Configuration
   input wire logic [1:0] out_words_i,
   input wire logic [NCH*`ADCF_CODE_W-1:0] hi_thr_i,
   input wire logic [NCH*HYS_W-1:0] hi_hys_i,
   input wire logic [NCH*`ADCF_CODE_W-1:0] lo_thr_i,
   input wire logic [NCH*HYS_W-1:0] lo_hys_i,
   output logic [`ADCF_WORD_W-1:0] cfg_word_o,
   // Alarm flags
   input wire logic hi_flag_rd_i,
   input wire logic lo_flag_rd_i,
   output logic [NCH-1:0] act_hi_o,
   output logic [NCH-1:0] act_lo_o,
   output logic [NCH-1:0] trip_hi_o,
   output logic [NCH-1:0] trip_lo_o
);

   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic cs_p;
      logic cfg_m;
      logic cfg_s;
      logic cfg_p;
      logic evt_m;
      logic evt_s;
      logic evt_p;
      logic link_rst;
      adcf_pkg::adcf_conv_st_t st;
      logic conv_start;
      logic [CH_W-1:0] conv_ch;
      logic [`ADCF_WORD_W-1:0] pend_cfg;
      logic [`ADCF_WORD_W-1:0] act_cfg;
      logic [`ADCF_WORD_W-1:0] result;
      logic [NCH-1:0] act_hi;
      logic [NCH-1:0] act_lo;
      logic [NCH-1:0] trip_hi;
      logic [NCH-1:0] trip_lo;
      logic alarm;
      logic oe;
   } adcf_sys_t;

   typedef struct packed {
      logic [`ADCF_CNT_W-1:0] cnt;
      logic [`ADCF_WORD_W-2:0] cfg_sh;
      logic [`ADCF_WORD_W-1:0] out_sh;
      logic sdo;
   } adcf_frm_t;

   typedef struct packed {
      logic [`ADCF_WORD_W-1:0] cfg_word;
      logic cfg_tgl;
      logic evt_tgl;
      logic [1:0] wd_m;
      logic [1:0] wd_s;
   } adcf_lnk_t;

   localparam adcf_sys_t SYS_RST = '{
      st: adcf_pkg::ADCF_IDLE,
      link_rst: 1'b1,
      cs_m: 1'b1,
      cs_s: 1'b1,
      cs_p: 1'b1,
      pend_cfg: `ADCF_CFG_RST,
      act_cfg: `ADCF_CFG_RST,
      default: '0
   };

   adcf_sys_t s_reg;
   adcf_sys_t s_next;
   adcf_frm_t f_reg;
   adcf_frm_t f_next;
   adcf_lnk_t l_reg;
   adcf_lnk_t l_next;

   // Widen an unsigned code or hysteresis for signed limit math
   function automatic adcf_pkg::adcf_cmp_t ext_code(input logic [`ADCF_CODE_W-1:0] v);
      ext_code = adcf_pkg::adcf_cmp_t'({3'b000, v});
   endfunction

   function automatic adcf_pkg::adcf_cmp_t ext_hys(input logic [HYS_W-1:0] v);
      ext_hys = adcf_pkg::adcf_cmp_t'({{(15-HYS_W){1'b0}}, v});
   endfunction

   // Frame end edge: own word on edges 16 to 31 plus 16 edges per programmed chained word
   function automatic logic [`ADCF_CNT_W-1:0] last_edge(input logic [1:0] words);
      last_edge = `ADCF_CFG_EDGES + {words + 2'd0, 4'h0} + 7'h0f;
   endfunction

   // ---------------- System domain ----------------
   always_comb begin
      adcf_pkg::adcf_cmp_t code;
      adcf_pkg::adcf_cmp_t hthr;
      adcf_pkg::adcf_cmp_t hhys;
      adcf_pkg::adcf_cmp_t lthr;
      adcf_pkg::adcf_cmp_t lhys;
      logic cs_fall;
      code = '0;
      hthr = '0;
      hhys = '0;
      lthr = '0;
      lhys = '0;
      cs_fall = 1'b0;
      s_next = s_reg;
      s_next.cs_m = cs_n_i;
      s_next.cs_s = s_reg.cs_m;
      s_next.cs_p = s_reg.cs_s;
      s_next.cfg_m = l_reg.cfg_tgl;
      s_next.cfg_s = s_reg.cfg_m;
      s_next.cfg_p = s_reg.cfg_s;
      s_next.evt_m = l_reg.evt_tgl;
      s_next.evt_s = s_reg.evt_m;
      s_next.evt_p = s_reg.evt_s;
      s_next.link_rst = 1'b0;
      s_next.conv_start = 1'b0;
      s_next.oe = ~s_reg.cs_s;
      cs_fall = s_reg.cs_p & ~s_reg.cs_s;
      if (s_reg.cfg_s != s_reg.cfg_p) begin
         s_next.pend_cfg = l_reg.cfg_word;
      end
      if (cs_fall) begin
         s_next.act_cfg = s_reg.pend_cfg;
         s_next.conv_ch = s_reg.pend_cfg[`ADCF_CFG_CH_LSB +: CH_W];
         s_next.conv_start = 1'b1;
         s_next.st = adcf_pkg::ADCF_CONV;
      end
      case (s_reg.st)
         adcf_pkg::ADCF_IDLE: begin
         end
         adcf_pkg::ADCF_CONV: begin
            if (conv_done_i && !cs_fall) begin
               s_next.st = adcf_pkg::ADCF_IDLE;
               // Straight binary code, zero padded below
               s_next.result = {conv_code_i, {`ADCF_PAD_W{1'b0}}};
               code = ext_code(conv_code_i);
               for (int i = 0; i < NCH; i++) begin
                  if (s_reg.conv_ch == CH_W'(i)) begin
                     hthr = ext_code(hi_thr_i[i*`ADCF_CODE_W +: `ADCF_CODE_W]);
                     hhys = ext_hys(hi_hys_i[i*HYS_W +: HYS_W]);
                     lthr = ext_code(lo_thr_i[i*`ADCF_CODE_W +: `ADCF_CODE_W]);
                     lhys = ext_hys(lo_hys_i[i*HYS_W +: HYS_W]);
                     if (!s_reg.act_hi[i]) begin
                        s_next.act_hi[i] = code > hthr + hhys;
                     end else begin
                        s_next.act_hi[i] = !(code <= hthr - hhys - `ADCF_HI_CLR_OFS);
                     end
                     if (!s_reg.act_lo[i]) begin
                        s_next.act_lo[i] = code < lthr - lhys - `ADCF_LO_SET_OFS;
                     end else begin
                        s_next.act_lo[i] = !(code >= lthr + lhys + `ADCF_LO_CLR_OFS);
                     end
                  end
               end
            end
         end
         default: begin
            s_next.st = adcf_pkg::ADCF_IDLE;
         end
      endcase
      // Read clears, a new set in the same cycle wins
      s_next.trip_hi = (s_reg.trip_hi & ~{NCH{hi_flag_rd_i}}) | s_next.act_hi;
      s_next.trip_lo = (s_reg.trip_lo & ~{NCH{lo_flag_rd_i}}) | s_next.act_lo;
      if (s_reg.evt_s != s_reg.evt_p) begin
         s_next.alarm = |{s_reg.trip_hi, s_reg.trip_lo};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         s_reg <= SYS_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------- Link domain, falling serial edges ----------------
   always_comb begin
      logic [`ADCF_CNT_W-1:0] edge_no;
      edge_no = f_reg.cnt + 7'd1;
      f_next = f_reg;
      l_next = l_reg;
      l_next.wd_m = out_words_i;
      l_next.wd_s = l_reg.wd_m;
      if (f_reg.cnt != {`ADCF_CNT_W{1'b1}}) begin
         f_next.cnt = edge_no;
      end
      if (edge_no <= `ADCF_CFG_EDGES) begin
         f_next.cfg_sh = {f_reg.cfg_sh[`ADCF_WORD_W-3:0], sdi_i};
      end
      if (edge_no < `ADCF_CFG_EDGES) begin
         f_next.sdo = 1'b0;
      end else if (edge_no == `ADCF_CFG_EDGES) begin
         l_next.cfg_word = {f_reg.cfg_sh, sdi_i};
         l_next.cfg_tgl = ~l_reg.cfg_tgl;
         l_next.evt_tgl = ~l_reg.evt_tgl;
         // Result is static here since conversion ended before this edge
         f_next.sdo = s_reg.result[`ADCF_WORD_W-1];
         f_next.out_sh = s_reg.result;
      end else if (edge_no <= last_edge(l_reg.wd_s)) begin
         // Chain bit enters one edge after the upstream part shows its first bit
         f_next.sdo = f_reg.out_sh[`ADCF_WORD_W-2];
         f_next.out_sh = {f_reg.out_sh[`ADCF_WORD_W-2:0], daisy_i};
      end else begin
         f_next.sdo = 1'b0;
      end
   end

   // Frame state held clear while chip select is high
   always_ff @(negedge sclk_i or posedge cs_n_i or posedge s_reg.link_rst) begin
      if (cs_n_i || s_reg.link_rst) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   always_ff @(negedge sclk_i or posedge s_reg.link_rst) begin
      if (s_reg.link_rst) begin
         l_reg <= '{cfg_word: `ADCF_CFG_RST, default: '0};
      end else begin
         l_reg <= l_next;
      end
   end

   assign sdo_o = f_reg.sdo;
   assign sdo_oe_o = s_reg.oe;
   assign alarm_o = s_reg.alarm;
   assign conv_start_o = s_reg.conv_start;
   assign conv_ch_o = s_reg.conv_ch;
   assign cfg_word_o = s_reg.act_cfg;
   assign act_hi_o = s_reg.act_hi;
   assign act_lo_o = s_reg.act_lo;
   assign trip_hi_o = s_reg.trip_hi;
   assign trip_lo_o = s_reg.trip_lo;

endmodule // adcf_top

// ==== adcf_cfg.svh ====
`ifndef ADCF_CFG_SVH
`define ADCF_CFG_SVH
// Functional notes
// - Results are straight binary, same code format on every channel and range
// - Each result is a 12-bit code, one step is span over 4096
// - Alarm output is active high and changes only at falling serial edge 16
// - Alarm output is set at edge 16 high if any channel then has a tripped flag, else low
// - Every channel has its own high and low threshold, each with hysteresis
// - High alarm sets when code exceeds high threshold plus hysteresis
// - High alarm clears when code is at or below threshold minus hysteresis minus 2
// - Low alarm sets when code is below low threshold minus hysteresis minus 1
// - Low alarm clears when code is at or above threshold plus hysteresis plus 1
// - Active flags follow the live alarm condition
// - Tripped flags set like active flags and hold until their register is read
// - Chip select falling starts a frame, sampling and converting the chosen channel
// - Channel converted in a frame is the one configured in the previous frame
// - While chip select is high the converter stays idle
// - Serial transfers use falling edges of the host serial clock
// - First 16 falling edges of a frame capture the 16-bit configuration word
// - A received configuration takes effect at the next chip select fall
// - Serial output is driven while chip select is low, released when high
// - Serial output low for 15 edges, MSB on edge 16, then one bit per edge
// - After the whole output word the serial output stays low
// - Output frame length follows the programmed output format
// - Shift register loads the 12 result bits then four zero bits
// - From edge 17 up to the frame end edge each falling edge shifts in the chain input bit
`define ADCF_CODE_W 12
`define ADCF_WORD_W 16
`define ADCF_PAD_W 4
`define ADCF_CFG_EDGES 7'd16
`define ADCF_CNT_W 7
`define ADCF_CFG_CH_LSB 0
`define ADCF_HI_CLR_OFS 15'sd2
`define ADCF_LO_SET_OFS 15'sd1
`define ADCF_LO_CLR_OFS 15'sd1
`define ADCF_CFG_RST 16'h0000
`endif

// ==== adcf_pkg.sv ====
package adcf_pkg;
   typedef enum logic [1:0] {
      ADCF_IDLE = 2'b01,
      ADCF_CONV = 2'b10
   } adcf_conv_st_t;
   typedef logic signed [14:0] adcf_cmp_t;
endpackage

// ==== adcf_top_assertions.sv ====
`timescale 1ns/10ps
module adcf_chk #(
   parameter int NCH = 8
) (
   // System
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Link
   input wire logic cs_n_i,
   input wire logic sdo_o,
   input wire logic sdo_oe_o,
   input wire logic alarm_o,
   // Converter and flags
   input wire logic conv_start_o,
   input wire logic conv_done_i,
   input wire logic hi_flag_rd_i,
   input wire logic [NCH-1:0] act_hi_o,
   input wire logic [NCH-1:0] act_lo_o,
   input wire logic [NCH-1:0] trip_hi_o,
   input wire logic [NCH-1:0] trip_lo_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   a_alarm_in_frame: assert property ($changed(alarm_o) |-> !cs_n_i)
      else $error("alarm moved when idle");
   a_oe_release: assert property (cs_n_i [*5] |-> !sdo_oe_o)
      else $error("sdo enable stuck");
   a_oe_drive: assert property (!cs_n_i [*5] |-> sdo_oe_o)
      else $error("sdo enable missing");
   a_link_idle: assert property (cs_n_i [*5] |-> !sdo_o && !conv_start_o)
      else $error("link busy when idle");
   a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
      else $error("start pulse long");
   a_start_on_cs: assert property ($fell(cs_n_i) |-> ##[1:6] conv_start_o)
      else $error("no start");
   a_act_in_trip: assert property (
      ((act_hi_o & ~trip_hi_o) | (act_lo_o & ~trip_lo_o)) == '0)
      else $error("active without tripped");
   a_trip_hold: assert property (|($past(trip_hi_o) & ~trip_hi_o) |-> $past(hi_flag_rd_i))
      else $error("tripped flag lost");
   a_flag_cause: assert property ($changed({act_hi_o, act_lo_o}) |-> $past(conv_done_i))
      else $error("flags moved alone");
   cover property ($rose(alarm_o));
   cover property (conv_done_i);
   cover property (hi_flag_rd_i && trip_hi_o != '0);
endmodule // adcf_chk
bind adcf_top adcf_chk #(.NCH(NCH)) chk_u (
   .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sdo_o(sdo_o),
   .sdo_oe_o(sdo_oe_o), .alarm_o(alarm_o), .conv_start_o(conv_start_o),
   .conv_done_i(conv_done_i), .hi_flag_rd_i(hi_flag_rd_i), .act_hi_o(act_hi_o),
   .act_lo_o(act_lo_o), .trip_hi_o(trip_hi_o), .trip_lo_o(trip_lo_o)
);

// ==== adcf_host.sv ====
`timescale 1ns/10ps
module adcf_host #(
   parameter logic [15:0] UP_WORD = 16'hA5C0
) (
   // Link pins driven
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o,
   output logic daisy_o,
   // Serial data seen
   input wire logic sdo_i
);
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
      daisy_o = 1'b0;
   end
   // One frame of nf falling edges, sdo sampled before each
   task automatic frame(input logic [15:0] cfg, input int nf, output logic [127:0] rx);
      rx = '0;
      cs_n_o = 1'b0;
      sdi_o = cfg[15];
      daisy_o = 1'b0;
      #400;
      for (int k = 1; k <= nf; k++) begin
         #7.5 rx = {rx[126:0], sdo_i};
         sclk_o = 1'b0;
         sdi_o <= k < 16 ? cfg[15-k] : ~sdi_o;
         daisy_o <= k > 15 && k < 32 ? UP_WORD[31-k] : 1'b0;
         #7.5 sclk_o = 1'b1;
      end
      #20 cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      daisy_o = ~daisy_o;
      #200;
   endtask
endmodule // adcf_host

// ==== adcf_top_tb.sv ====
`timescale 1ns/10ps
module adcf_top_tb;
   typedef struct packed {
      logic [15:0] cfg;
      logic [11:0] code;
      logic hi;
      logic lo;
   } adcf_row_t;
   localparam logic [15:0] UP = 16'hA5C0;
   localparam adcf_row_t ROWS [10] = '{
      '{16'h0002, 12'h200, 1'b0, 1'b0}, '{16'h0002, 12'h485, 1'b0, 1'b0},
      '{16'h0002, 12'h486, 1'b1, 1'b0}, '{16'h0002, 12'h47A, 1'b1, 1'b0},
      '{16'h0002, 12'h479, 1'b0, 1'b0}, '{16'h0002, 12'h0FF, 1'b0, 1'b0},
      '{16'h0002, 12'h0FE, 1'b0, 1'b1}, '{16'h0002, 12'h104, 1'b0, 1'b1},
      '{16'h5A07, 12'h105, 1'b0, 1'b0}, '{16'hC3F8, 12'hFFF, 1'b1, 1'b0}};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic conv_done = 1'b0;
   logic hi_rd = 1'b0;
   logic lo_rd = 1'b0;
   logic [1:0] out_words = 2'b00;
   logic [11:0] code_now = 12'h000;
   logic sclk, cs_n, sdi, daisy, sdo, sdo_oe, alarm, conv_start;
   logic [2:0] conv_ch;
   logic [15:0] cfg_word, prev_cfg;
   logic [7:0] act_hi, act_lo, trip_hi, trip_lo, exp_th, exp_tl;
   logic [95:0] hi_thr, lo_thr;
   logic [63:0] hi_hys, lo_hys;
   logic [127:0] rx;
   wire sdo_pin = sdo_oe ? sdo : 1'bz;
   int bad_count = 0;
   int checks_done = 0;
   initial begin
      forever #20 clk = ~clk;
   end
   // Converter core answers each start
   always @(negedge clk) conv_done <= conv_start;
   adcf_host #(.UP_WORD(UP)) host_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
      .daisy_o(daisy), .sdo_i(sdo_pin));
   adcf_top dut_u (
      .clk_sys_i(clk), .resetn_i(resetn), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
      .daisy_i(daisy), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .alarm_o(alarm),
      .conv_start_o(conv_start), .conv_ch_o(conv_ch), .conv_done_i(conv_done),
      .conv_code_i(code_now), .out_words_i(out_words), .hi_thr_i(hi_thr), .hi_hys_i(hi_hys),
      .lo_thr_i(lo_thr), .lo_hys_i(lo_hys), .cfg_word_o(cfg_word), .hi_flag_rd_i(hi_rd),
      .lo_flag_rd_i(lo_rd), .act_hi_o(act_hi), .act_lo_o(act_lo), .trip_hi_o(trip_hi),
      .trip_lo_o(trip_lo));
   task automatic tally(input logic ok, input string what);
      checks_done++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      tally(got === exp, what);
   endtask
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp, input string what);
      tally(got === exp, what);
   endtask
   task automatic chk_rx(input logic [127:0] exp);
      tally(rx === exp, "sdo stream");
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask
   // Sample j is sdo after falling edge j; sample 0 follows chip select
   function automatic logic [127:0] exp_rx(input logic [15:0] own, input int w, input int f);
      logic [127:0] e;
      e = '0;
      for (int j = 16; j < 32; j++) e[f-1-j] = own[31-j];
      for (int j = 32; j < 48 && w > 0; j++) e[f-1-j] = UP[47-j];
      return e;
   endfunction
   task automatic wrap_up;
      if (bad_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 8; i++) begin
         hi_thr[i*12 +: 12] = 12'h400 + 12'(i * 64);
         hi_hys[i*8 +: 8] = 8'h03 + 8'(i);
         lo_thr[i*12 +: 12] = 12'h100 + 12'(i);
         lo_hys[i*8 +: 8] = 8'h02;
      end
      prev_cfg = 16'h0000;
      exp_th = 8'h00;
      exp_tl = 8'h00;
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      repeat (5) @(negedge clk);
      chk_bit(sdo_oe | alarm, 1'b0, "reset outputs");
      for (int i = 0; i < 10; i++) begin
         @(negedge clk) out_words = 2'(i % 4);
         code_now = ROWS[i].code;
         host_u.frame(ROWS[i].cfg, 35 + 16 * (i % 4), rx);
         chk_w(cfg_word, prev_cfg, "config");
         chk_w(16'(conv_ch), 16'(prev_cfg[2:0]), "channel");
         chk_bit(act_hi[prev_cfg[2:0]], ROWS[i].hi, "high alarm");
         chk_bit(act_lo[prev_cfg[2:0]], ROWS[i].lo, "low alarm");
         exp_th[prev_cfg[2:0]] |= ROWS[i].hi;
         exp_tl[prev_cfg[2:0]] |= ROWS[i].lo;
         chk_bit(alarm, |{exp_th, exp_tl}, "alarm");
         chk_rx(exp_rx({ROWS[i].code, 4'h0}, i % 4, 35 + 16 * (i % 4)));
         prev_cfg = ROWS[i].cfg;
      end
      chk_w({trip_hi, trip_lo}, {exp_th, exp_tl}, "tripped");
      pulse(hi_rd);
      @(negedge clk);
      chk_w({trip_hi, trip_lo}, {8'h80, exp_tl}, "high read");
      pulse(lo_rd);
      @(negedge clk);
      chk_w({trip_hi, trip_lo}, 16'h8000, "low read");
      @(negedge clk) resetn = 1'b0;
      repeat (2) @(negedge clk);
      chk_w({trip_hi, trip_lo}, 16'h0000, "reset flags");
      chk_bit(alarm, 1'b0, "reset alarm");
      resetn = 1'b1;
      out_words = 2'b00;
      code_now = 12'h200;
      repeat (5) @(negedge clk);
      host_u.frame(16'h0000, 35, rx);
      chk_w(cfg_word, 16'h0000, "config after reset");
      chk_rx(exp_rx(16'h2000, 0, 35));
      wrap_up();
   end
   initial begin
      #100_000;
      bad_count++;
      wrap_up();
   end
endmodule // adcf_top_tb
